// ---- logic/csw_pkg.sv ----
package csw_pkg;

   // register port geometry
   localparam int unsigned CSW_AW = 8;
   localparam int unsigned CSW_DW = 16;

   // register byte offsets
   localparam logic [7:0] CSW_ADDR_SYSCFG   = 8'h00;
   localparam logic [7:0] CSW_ADDR_IRQ_STAT = 8'h04;
   localparam logic [7:0] CSW_ADDR_IRQ_CLR  = 8'h08;
   localparam logic [7:0] CSW_ADDR_IRQ_EN   = 8'h0C;
   localparam logic [7:0] CSW_ADDR_BUSCFG   = 8'h10;
   localparam logic [7:0] CSW_ADDR_CLKSTAT  = 8'h14;

   // field positions
   localparam int unsigned CSW_SUP_DIS_BIT  = 4;
   localparam int unsigned CSW_IRQ_FAIL_BIT = 0;
   localparam int unsigned CSW_CYC_LSB      = 0;
   localparam int unsigned CSW_CYC_W        = 4;
   localparam int unsigned CSW_TRI_BIT      = 5;
   localparam int unsigned CSW_ALE_BIT      = 9;
   localparam int unsigned CSW_STAT_SRC_LSB = 3;
   localparam int unsigned CSW_STAT_DIS_BIT = 8;

   // reset values
   localparam logic [15:0] CSW_SYSCFG_RST = 16'h0000;
   localparam logic [15:0] CSW_BUSCFG_RST = 16'h0000;
   localparam logic        CSW_IRQ_RST    = 1'h0;

   // clock-mode pin codes
   localparam logic [2:0] CSW_MODE_DIRECT = 3'h3;
   localparam logic [2:0] CSW_MODE_PRESC  = 3'h1;

   // timing counts
   localparam logic [3:0] CSW_WDG_LAST  = 4'hF;  // 16th free-running edge overflows
   localparam logic [2:0] CSW_SETTLE    = 3'h4;  // filtered straps are valid from the 4th edge
   localparam logic [3:0] CSW_CYC_MAX   = 4'hF;

   typedef enum logic [4:0] {
      CSW_SRC_RESET  = 5'h01,
      CSW_SRC_DIRECT = 5'h02,
      CSW_SRC_PRESC  = 5'h04,
      CSW_SRC_PLL    = 5'h08,
      CSW_SRC_FAIL   = 5'h10
   } csw_src_t;

   // oscillator edges (both directions) between two PLL resyncs, i.e. 2 x F
   function automatic logic [3:0] csw_resync_edges(input logic [2:0] mode);
      logic [3:0] e;
      e = 4'h8;
      case (mode)
         3'h7:    e = 4'h8;
         3'h6:    e = 4'h6;
         3'h5:    e = 4'h4;
         3'h4:    e = 4'hA;
         3'h2:    e = 4'h3;
         3'h0:    e = 4'h5;
         default: e = 4'h2;
      endcase
      return e;
   endfunction

endpackage

// ---- logic/csw_sync.sv ----
`timescale 1ns/1ps
module csw_sync #(
   parameter int unsigned W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         reset_n,
   // asynchronous level in, filtered level out
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   import csw_pkg::*;

   typedef struct packed {
      logic [W-1:0] ff1;
      logic [W-1:0] ff2;
      logic [W-1:0] ff3;
      logic [W-1:0] q;
   } csw_sync_st_t;

   csw_sync_st_t s_q;
   csw_sync_st_t s_d;

   if (W < 1) begin : g_bad_width
      $error("csw_sync: W must be at least 1");
   end

   // ff1 feeds ff2 only; a change is accepted once ff2 and ff3 agree
   always_comb begin
      s_d     = s_q;
      s_d.ff1 = d;
      s_d.ff2 = s_q.ff1;
      s_d.ff3 = s_q.ff2;
      if (s_q.ff2 == s_q.ff3) begin
         s_d.q = s_q.ff3;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign q = s_q.q;

endmodule

// ---- logic/csw_clock_ctrl.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - mode 011: cpu clock follows oscillator directly
// - mode 001: cpu clock is oscillator halved
// - supervision active after reset without software
// - disable bit 4 turns supervision off
// - enabled: free-running pll edges count up
// - each oscillator transition clears the counter
// - sixteen pll edges without transition: failure
// - failure: switch to pll, raise irq flag
// - failure sticks until hardware reset
// - disabled: pll powered off in modes 011/001 only, kept on in pll mode and after failure
// - other codes: pll on, multiply by factor
// - pll resyncs every 2 x F input transitions
// - ale extension and tri-state time from fields
// - wait time two tcl times fifteen minus field
module csw_clock_ctrl (
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       reset_n,
   // pins from outside
   input  wire logic [2:0]                 clock_mode_pins,
   input  wire logic                       osc_input_pin,
   input  wire logic                       pll_clk_in,
   // register port
   input  wire logic [csw_pkg::CSW_AW-1:0] reg_addr,
   input  wire logic [csw_pkg::CSW_DW-1:0] reg_wdata,
   input  wire logic                       reg_wr,
   input  wire logic                       reg_rd,
   output logic      [csw_pkg::CSW_DW-1:0] reg_rdata,
   // clock outputs
   output logic                            cpu_clk,
   output csw_pkg::csw_src_t               clk_src,
   output logic                            pll_power_on,
   output logic                            pll_free_run,
   output logic      [2:0]                 pll_factor,
   output logic                            pll_resync,
   // bus timing in tcl units
   output logic                            ale_ext_tcl,
   output logic      [4:0]                 wait_tcl,
   output logic      [1:0]                 tristate_tcl,
   // interrupt
   output logic                            clock_fail_irq
);
   import csw_pkg::*;

   typedef struct packed {
      logic [2:0]  settle;
      logic [2:0]  mode;
      csw_src_t    src;
      logic        sup_dis;
      logic [3:0]  wdg_cnt;
      logic        osc_prev;
      logic        pll_prev;
      logic [3:0]  resync_cnt;
      logic        irq_stat;
      logic        irq_en;
      logic [15:0] buscfg;
      logic [15:0] rdata;
      logic        cpu_clk;
      logic        pll_power;
      logic        pll_free;
      logic        resync;
      logic        irq;
      logic        ale_ext;
      logic [4:0]  wait_tcl;
      logic [1:0]  tri_tcl;
   } csw_st_t;

   csw_st_t    s_q;
   csw_st_t    s_d;
   logic [2:0] mode_s;
   logic       osc_s;
   logic       pll_s;
   logic       osc_edge;
   logic       osc_rise;
   logic       pll_rise;
   logic       fail_evt;
   logic       wdg_on;
   logic [3:0] cyc_fld;

   csw_sync #(.W(3)) u_sync_mode (
      .clk     (clk),
      .reset_n (reset_n),
      .d       (clock_mode_pins),
      .q       (mode_s)
   );

   csw_sync #(.W(1)) u_sync_osc (
      .clk     (clk),
      .reset_n (reset_n),
      .d       (osc_input_pin),
      .q       (osc_s)
   );

   csw_sync #(.W(1)) u_sync_pll (
      .clk     (clk),
      .reset_n (reset_n),
      .d       (pll_clk_in),
      .q       (pll_s)
   );

   assign osc_edge = osc_s ^ s_q.osc_prev;
   assign osc_rise = osc_s & ~s_q.osc_prev;
   assign pll_rise = pll_s & ~s_q.pll_prev;
   // the watchdog stops once failed: nothing could undo the switch anyway
   assign wdg_on   = !s_q.sup_dis && (s_q.src != CSW_SRC_RESET) && (s_q.src != CSW_SRC_FAIL);

   always_comb begin
      s_d          = s_q;
      fail_evt     = 1'b0;
      cyc_fld      = 4'h0;
      s_d.osc_prev = osc_s;
      s_d.pll_prev = pll_s;
      s_d.resync   = 1'b0;

      // source selection
      unique case (s_q.src)
         CSW_SRC_RESET: begin
            s_d.cpu_clk = 1'b0;
            if (s_q.settle == CSW_SETTLE) begin
               s_d.mode = mode_s;
               if (mode_s == CSW_MODE_DIRECT) begin
                  s_d.src = CSW_SRC_DIRECT;
               end else if (mode_s == CSW_MODE_PRESC) begin
                  s_d.src = CSW_SRC_PRESC;
               end else begin
                  s_d.src = CSW_SRC_PLL;
               end
            end else begin
               // the mode filter shows the pins only after four edges; latching earlier
               // would take its reset value
               s_d.settle = s_q.settle + 3'h1;
            end
         end
         CSW_SRC_DIRECT: begin
            s_d.cpu_clk = osc_s;
         end
         CSW_SRC_PRESC: begin
            if (osc_rise) begin
               s_d.cpu_clk = ~s_q.cpu_clk;
            end
         end
         CSW_SRC_PLL: begin
            s_d.cpu_clk = pll_s;
            if (osc_edge) begin
               if (s_q.resync_cnt == csw_resync_edges(s_q.mode) - 4'h1) begin
                  s_d.resync_cnt = 4'h0;
                  s_d.resync     = 1'b1;
               end else begin
                  s_d.resync_cnt = s_q.resync_cnt + 4'h1;
               end
            end
         end
         CSW_SRC_FAIL: begin
            s_d.cpu_clk = pll_s;
         end
      endcase

      // oscillator supervision
      if (!wdg_on) begin
         s_d.wdg_cnt = 4'h0;
      end else if (osc_edge) begin
         s_d.wdg_cnt = 4'h0;
      end else if (pll_rise) begin
         if (s_q.wdg_cnt == CSW_WDG_LAST) begin
            fail_evt = 1'b1;
         end else begin
            s_d.wdg_cnt = s_q.wdg_cnt + 4'h1;
         end
      end
      if (fail_evt) begin
         s_d.src     = CSW_SRC_FAIL;
         s_d.wdg_cnt = 4'h0;
      end

      // register writes; a failure in the clearing cycle still sets the flag
      if (reg_wr) begin
         unique case (reg_addr)
            CSW_ADDR_SYSCFG:   s_d.sup_dis = reg_wdata[CSW_SUP_DIS_BIT];
            CSW_ADDR_IRQ_CLR: begin
               if (reg_wdata[CSW_IRQ_FAIL_BIT]) begin
                  s_d.irq_stat = 1'b0;
               end
            end
            CSW_ADDR_IRQ_EN:   s_d.irq_en = reg_wdata[CSW_IRQ_FAIL_BIT];
            CSW_ADDR_BUSCFG:   s_d.buscfg = reg_wdata;
            default: begin
            end
         endcase
      end
      if (fail_evt) begin
         s_d.irq_stat = 1'b1;
      end

      // register reads, answered the next cycle only
      s_d.rdata = 16'h0000;
      if (reg_rd) begin
         unique case (reg_addr)
            CSW_ADDR_SYSCFG:   s_d.rdata[CSW_SUP_DIS_BIT]  = s_q.sup_dis;
            CSW_ADDR_IRQ_STAT: s_d.rdata[CSW_IRQ_FAIL_BIT] = s_q.irq_stat;
            CSW_ADDR_IRQ_EN:   s_d.rdata[CSW_IRQ_FAIL_BIT] = s_q.irq_en;
            CSW_ADDR_BUSCFG:   s_d.rdata = s_q.buscfg;
            CSW_ADDR_CLKSTAT: begin
               s_d.rdata[2:0]                   = s_q.mode;
               s_d.rdata[CSW_STAT_SRC_LSB +: 5] = s_q.src;
               s_d.rdata[CSW_STAT_DIS_BIT]      = s_q.sup_dis;
            end
            default: begin
            end
         endcase
      end

      // pll runs for its own mode, after a failure, or free for the watchdog
      s_d.pll_power = (s_d.src == CSW_SRC_PLL) || (s_d.src == CSW_SRC_FAIL)
                      || !s_d.sup_dis;
      s_d.pll_free  = s_d.pll_power && (s_d.src != CSW_SRC_PLL);

      s_d.irq = s_d.irq_stat & s_d.irq_en;

      // bus timing variables
      cyc_fld       = s_d.buscfg[CSW_CYC_LSB +: CSW_CYC_W];
      s_d.ale_ext   = s_d.buscfg[CSW_ALE_BIT];
      s_d.tri_tcl   = {~s_d.buscfg[CSW_TRI_BIT], 1'b0};
      s_d.wait_tcl  = {CSW_CYC_MAX - cyc_fld, 1'b0};
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q          <= '0;
         s_q.src      <= CSW_SRC_RESET;
         s_q.sup_dis  <= CSW_SYSCFG_RST[CSW_SUP_DIS_BIT];
         s_q.buscfg   <= CSW_BUSCFG_RST;
         s_q.irq_stat <= CSW_IRQ_RST;
         s_q.wait_tcl <= {CSW_CYC_MAX, 1'b0};
         s_q.tri_tcl  <= 2'h2;
         s_q.pll_power <= 1'b1;
         s_q.pll_free <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata      = s_q.rdata;
   assign cpu_clk        = s_q.cpu_clk;
   assign clk_src        = s_q.src;
   assign pll_power_on   = s_q.pll_power;
   assign pll_free_run   = s_q.pll_free;
   assign pll_factor     = s_q.mode;
   assign pll_resync     = s_q.resync;
   assign ale_ext_tcl    = s_q.ale_ext;
   assign wait_tcl       = s_q.wait_tcl;
   assign tristate_tcl   = s_q.tri_tcl;
   assign clock_fail_irq = s_q.irq;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   a_direct_follow: assert property (
      (s_q.src == CSW_SRC_DIRECT) |=> (cpu_clk == $past(osc_s)))
      else $error("direct mode clock does not follow oscillator");
   a_presc_toggle: assert property (
      (s_q.src == CSW_SRC_PRESC && osc_rise) |=> $changed(cpu_clk))
      else $error("prescaler missed an oscillator rising edge");
   // only the first cycle out of reset: software may write the bit while straps settle
   a_sup_default: assert property (
      (s_q.src == CSW_SRC_RESET && s_q.settle == 3'h0) |-> !s_q.sup_dis)
      else $error("supervision not enabled out of reset");
   a_sup_write: assert property (
      (reg_wr && reg_addr == CSW_ADDR_SYSCFG)
      |=> (s_q.sup_dis == $past(reg_wdata[CSW_SUP_DIS_BIT])))
      else $error("disable bit write not taken");
   a_sup_pll_on: assert property (
      !s_q.sup_dis |-> pll_power_on)
      else $error("pll unpowered while supervision enabled");
   a_wdg_count: assert property (
      (wdg_on && pll_rise && !osc_edge && s_q.wdg_cnt != CSW_WDG_LAST)
      |=> (s_q.wdg_cnt == $past(s_q.wdg_cnt) + 4'h1))
      else $error("watchdog counter did not advance");
   a_wdg_clear: assert property (
      (wdg_on && osc_edge) |=> (s_q.wdg_cnt == 4'h0 && s_q.src != CSW_SRC_FAIL))
      else $error("oscillator edge did not clear watchdog");
   a_wdg_overflow: assert property (
      (wdg_on && pll_rise && !osc_edge && s_q.wdg_cnt == CSW_WDG_LAST)
      |=> (s_q.src == CSW_SRC_FAIL && s_q.irq_stat) ##1 (clk_src == CSW_SRC_FAIL))
      else $error("overflow did not switch to failure");
   a_fail_sticky: assert property (
      (s_q.src == CSW_SRC_FAIL) |=> (s_q.src == CSW_SRC_FAIL && cpu_clk == $past(pll_s)))
      else $error("failure state left before reset");
   a_disabled_off: assert property (
      (s_q.sup_dis && (s_q.src == CSW_SRC_DIRECT || s_q.src == CSW_SRC_PRESC) && !reg_wr)
      |=> !pll_power_on)
      else $error("pll powered while supervision disabled");
   a_pll_follow: assert property (
      (s_q.src == CSW_SRC_PLL) |=> (cpu_clk == $past(pll_s)))
      else $error("pll mode clock does not follow pll");
   a_irq_level: assert property (
      clock_fail_irq == (s_q.irq_stat && s_q.irq_en))
      else $error("interrupt output does not match status and enable");
   a_resync_pulse: assert property (
      pll_resync |-> (clk_src == CSW_SRC_PLL && s_q.resync_cnt == 4'h0))
      else $error("resync pulse outside pll mode");
   a_bus_timing: assert property (
      (wait_tcl == {CSW_CYC_MAX - s_q.buscfg[3:0], 1'b0})
      && (tristate_tcl == (s_q.buscfg[CSW_TRI_BIT] ? 2'h0 : 2'h2)))
      else $error("bus timing outputs mismatch field");
   a_ale_field: assert property (
      ale_ext_tcl == s_q.buscfg[CSW_ALE_BIT])
      else $error("ale extension does not match field");
   a_strap_latch: assert property (
      (s_q.src == CSW_SRC_RESET && s_q.settle == CSW_SETTLE) |=> (s_q.mode == $past(mode_s)))
      else $error("clock mode not taken from filtered pins");
   a_mode_hold: assert property (
      (s_q.src != CSW_SRC_RESET) |=> $stable(s_q.mode))
      else $error("latched clock mode changed after reset");

   c_direct_mode: cover property (s_q.src == CSW_SRC_DIRECT ##1 $changed(cpu_clk));
   c_presc_mode:  cover property (s_q.src == CSW_SRC_PRESC ##1 $changed(cpu_clk));
   c_fail_switch: cover property ($rose(s_q.src == CSW_SRC_FAIL));
   c_pll_resync:  cover property (pll_resync);
   c_irq_clear:   cover property (clock_fail_irq ##[1:20] !clock_fail_irq);

endmodule

// ---- verif/csw_osc_model.sv ----
`timescale 1ns/1ps
// crystal source plus the pll free-running output that feeds the supervisor
module csw_osc_model #(
   parameter int OSC_HALF = 6,
   parameter int PLL_HALF = 5
) (
   // clock
   input  wire logic clk,
   // controls: a dead crystal freezes its level, an unpowered pll stops
   input  wire logic run,
   input  wire logic pwr,
   // source outputs
   output logic      osc,
   output logic      pll
);
   int oc = 0;
   int pc = 0;

   initial begin
      osc = 1'b0;
      pll = 1'b0;
   end

   // each level lasts at least four clk cycles so the filters see it
   always @(posedge clk) begin
      if (pwr) begin
         pc <= (pc == PLL_HALF - 1) ? 0 : pc + 1;
         if (pc == PLL_HALF - 1) pll <= ~pll;
      end
      if (run) begin
         oc <= (oc == OSC_HALF - 1) ? 0 : oc + 1;
         if (oc == OSC_HALF - 1) osc <= ~osc;
      end
   end
endmodule

// ---- verif/test_cpu_clock_source_and_osc_watchdog.sv ----
`timescale 1ns/1ps
module test_cpu_clock_source_and_osc_watchdog;
   import csw_pkg::*;
   logic        clk;
   logic        reset_n = 1'b0;
   logic [2:0]  mode = 3'h3;
   logic        run = 1'b1;
   logic [7:0]  reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic        osc, pll, cpu_clk, pll_power_on, pll_free_run, pll_resync;
   logic        ale_ext_tcl, clock_fail_irq;
   logic [2:0]  pll_factor;
   logic [4:0]  wait_tcl;
   logic [1:0]  tristate_tcl;
   csw_src_t    clk_src;
   int          err_count = 0;
   int          n_compared = 0;
   int          e_tab[8] = '{5, 0, 3, 0, 10, 4, 6, 8};

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   csw_osc_model osc_u (.clk(clk), .run(run), .pwr(pll_power_on), .osc(osc), .pll(pll));

   csw_clock_ctrl dut_u (
      .clk(clk), .reset_n(reset_n), .clock_mode_pins(mode), .osc_input_pin(osc),
      .pll_clk_in(pll), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_clk(cpu_clk), .clk_src(clk_src),
      .pll_power_on(pll_power_on), .pll_free_run(pll_free_run), .pll_factor(pll_factor),
      .pll_resync(pll_resync), .ale_ext_tcl(ale_ext_tcl), .wait_tcl(wait_tcl),
      .tristate_tcl(tristate_tcl), .clock_fail_irq(clock_fail_irq));

   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t ns: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      tick(2);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask

   task automatic do_reset(input logic [2:0] m);
      @(posedge clk);
      reset_n <= 1'b0;
      mode <= m;
      run <= 1'b1;
      tick(8);
      chk(16'(clk_src), 16'(CSW_SRC_RESET));
      @(posedge clk);
      reset_n <= 1'b1;
      tick(12);
   endtask

   task automatic t_reset;
      do_reset(3'h3);
      chk(16'(wait_tcl), 16'h001E);
      chk(16'(tristate_tcl), 16'h0002);
      chk(16'({pll_power_on, pll_free_run}), 16'h0003);
      rdchk(CSW_ADDR_SYSCFG, 16'h0000);
      rdchk(CSW_ADDR_IRQ_EN, 16'h0000);
      rdchk(CSW_ADDR_IRQ_STAT, 16'h0000);
      $display("test reset done");
   endtask

   task automatic t_modes;
      int nc, no, nr, gap, i, g;
      logic pc, po;
      csw_src_t s;
      for (int m = 0; m < 8; m++) begin
         do_reset(3'(m));
         s = (m == 3) ? CSW_SRC_DIRECT : (m == 1) ? CSW_SRC_PRESC : CSW_SRC_PLL;
         chk(16'(clk_src), 16'(s));
         chk(16'(pll_factor), 16'(m));
         chk(16'(pll_power_on), 16'h0001);
         chk(16'(pll_free_run), 16'(s != CSW_SRC_PLL));
         rdchk(CSW_ADDR_CLKSTAT, (16'(s) << 3) | 16'(m));
         mode <= ~3'(m);
         nc = 0; no = 0; nr = 0; gap = 0; g = 0;
         po = osc;
         pc = cpu_clk;
         for (i = 0; i < 300; i++) begin
            tick(1);
            if (osc !== po) g++;
            if (osc !== po) no++;
            if (cpu_clk !== pc) nc++;
            if (pll_resync === 1'b1) begin
               nr++;
               if (nr == 2) gap = g;
               g = 0;
            end
            po = osc;
            pc = cpu_clk;
         end
         chk(16'(clk_src), 16'(s));
         if (m == 3) chk(16'(nc > no + 1 || nc + 1 < no), 16'h0000);
         if (m == 1) chk(16'(2 * nc > no + 2 || 2 * nc + 2 < no), 16'h0000);
         if (m == 1 || m == 3) chk(16'(nr), 16'h0000);
         else chk(16'(gap), 16'(e_tab[m]));
      end
      $display("test modes done");
   endtask

   task automatic t_fail;
      int i, n;
      logic po, pp;
      do_reset(3'h3);
      wr(CSW_ADDR_IRQ_EN, 16'h0001);
      po = osc;
      for (i = 0; i < 20 && osc === po; i++) tick(1);
      chk(16'(osc !== po), 16'h0001);
      pp = pll;
      n = 0;
      for (i = 0; i < 300 && clk_src !== CSW_SRC_FAIL; i++) begin
         @(posedge clk);
         run <= 1'b0;
         #1;
         if (pll && !pp) n++;
         pp = pll;
      end
      chk(16'(n), 16'h0010);
      tick(1);
      chk(16'(clk_src), 16'(CSW_SRC_FAIL));
      chk(16'(pll_free_run), 16'h0001);
      chk(16'(clock_fail_irq), 16'h0001);
      rdchk(CSW_ADDR_IRQ_STAT, 16'h0001);
      run <= 1'b1;
      tick(100);
      chk(16'(clk_src), 16'(CSW_SRC_FAIL));
      wr(CSW_ADDR_IRQ_EN, 16'h0000);
      chk(16'(clock_fail_irq), 16'h0000);
      wr(CSW_ADDR_IRQ_EN, 16'h0001);
      chk(16'(clock_fail_irq), 16'h0001);
      wr(CSW_ADDR_IRQ_CLR, 16'h0001);
      chk(16'(clock_fail_irq), 16'h0000);
      rdchk(CSW_ADDR_IRQ_STAT, 16'h0000);
      wr(CSW_ADDR_SYSCFG, 16'h0010);
      chk(16'(clk_src), 16'(CSW_SRC_FAIL));
      do_reset(3'h3);
      chk(16'(clk_src), 16'(CSW_SRC_DIRECT));
      $display("test fail done");
   endtask

   task automatic t_disable;
      do_reset(3'h3);
      wr(CSW_ADDR_SYSCFG, 16'h0010);
      rdchk(CSW_ADDR_SYSCFG, 16'h0010);
      chk(16'(pll_power_on), 16'h0000);
      rdchk(CSW_ADDR_CLKSTAT, 16'h0100 | (16'(CSW_SRC_DIRECT) << 3) | 16'h0003);
      wr(CSW_ADDR_IRQ_EN, 16'h0001);
      run <= 1'b0;
      tick(300);
      chk(16'(clk_src), 16'(CSW_SRC_DIRECT));
      chk(16'(clock_fail_irq), 16'h0000);
      run <= 1'b1;
      $display("test disable done");
   endtask

   task automatic t_bus;
      logic [15:0] tab[3] = '{16'h0007, 16'h022F, 16'h0220};
      foreach (tab[k]) begin
         wr(CSW_ADDR_BUSCFG, tab[k]);
         chk(16'(wait_tcl), 16'(2 * (15 - tab[k][3:0])));
         chk(16'(tristate_tcl), 16'(2 * (1 - tab[k][5])));
         chk(16'(ale_ext_tcl), 16'(tab[k][9]));
         rdchk(CSW_ADDR_BUSCFG, tab[k]);
      end
      wr(8'h20, 16'hFFFF);
      rdchk(8'h20, 16'h0000);
      rdchk(CSW_ADDR_BUSCFG, tab[2]);
      rdchk(CSW_ADDR_IRQ_CLR, 16'h0000);
      $display("test bus done");
   endtask

   initial begin
      t_reset();
      t_modes();
      t_fail();
      t_disable();
      t_bus();
      print_verdict();
   end
endmodule
